// [ookt_config_regs.sv]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
//
// Contract
// - threshold field is fixed or floor level
// - peak decays by step code in half dB
// - peak update rate from rate code
// - averaging cutoff set by coefficient code
// - pattern sent first byte first, msb
// - transmit smoothing bandwidth from K, reset 7
// - output power code in bits 3:1
// - pattern byte count 1 to 4
// - detection only when recognition enabled
module ookt_config_regs
   import ookt_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receive path
   input wire logic [7:0] rssi_i,
   input wire logic rssi_valid_i,
   input wire logic chip_tick_i,
   input wire logic sub_tick_i,
   input wire logic rx_bit_i,
   input wire logic rx_bit_tick_i,
   output logic [7:0] slicer_threshold_o,
   output logic slice_bit_o,
   output logic pattern_found_o,
   // transmit path and averaging shift
   input wire logic tx_start_i,
   input wire logic tx_bit_tick_i,
   output logic tx_busy_o,
   output logic tx_bit_o,
   output logic [3:0] transmit_smoothing_bw_o,
   output logic [2:0] tx_power_code_o,
   output logic [2:0] average_filter_coeff_o
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] byte_mask(input logic [1:0] cnt);
      byte_mask = 32'hFFFF_FFFF >> {3'b011 - {1'b0, cnt}, 3'b000};
   endfunction

   function automatic logic [7:0] step_half_db(input logic [2:0] code);
      if (code[2]) begin
         step_half_db = ({6'h00, code[1:0]} + 8'h03) << 1;
      end else begin
         step_half_db = {5'h00, code} + 8'h01;
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] pat_ctrl_q, pat_ctrl_d;
   logic [7:0] thresh_q, thresh_d;
   logic [7:0] rssi_q, rssi_d;
   logic [7:0] peak_avg_q, peak_avg_d;
   logic [7:0] pat_q [4];
   logic [7:0] pat_d [4];
   logic [7:0] tx_cfg_q, tx_cfg_d;
   logic [7:0] mode_q, mode_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;

   logic setup;
   logic wr_en;
   logic [5:0] idx;
   logic hit;
   logic [7:0] rd_byte;

   assign setup = psel && !penable;
   assign idx = paddr[7:2];
   assign wr_en = psel && penable && pwrite && !pslverr;
   assign pready = 1'b1;
   assign prdata = rdata_q;
   assign pslverr = err_q && psel && penable;

   // ----------------------------------------
   // address decode and read mux
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         IDX_PAT_CTRL: rd_byte = pat_ctrl_q;
         IDX_THRESH: rd_byte = thresh_q;
         IDX_RSSI: rd_byte = rssi_q;
         IDX_PEAK_AVG: rd_byte = peak_avg_q;
         IDX_PAT_FIRST: rd_byte = pat_q[0];
         IDX_PAT_SECOND: rd_byte = pat_q[1];
         IDX_PAT_THIRD: rd_byte = pat_q[2];
         IDX_PAT_LAST: rd_byte = pat_q[3];
         IDX_TX_CFG: rd_byte = tx_cfg_q;
         IDX_SLICE_MODE: rd_byte = mode_q;
         default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end
   end

   always_comb begin
      rdata_d = rdata_q;
      err_d = err_q;
      if (setup) begin
         err_d = !hit;
         rdata_d = (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb begin
      pat_ctrl_d = pat_ctrl_q;
      thresh_d = thresh_q;
      peak_avg_d = peak_avg_q;
      tx_cfg_d = tx_cfg_q;
      mode_d = mode_q;
      for (int i = 0; i < 4; i++) begin
         pat_d[i] = pat_q[i];
      end
      rssi_d = rssi_valid_i ? rssi_i : rssi_q;
      if (wr_en) begin
         case (idx)
            IDX_PAT_CTRL: pat_ctrl_d = pwdata[7:0] & PAT_CTRL_MASK;
            IDX_THRESH: thresh_d = pwdata[7:0];
            IDX_PEAK_AVG: peak_avg_d = pwdata[7:0];
            IDX_PAT_FIRST: pat_d[0] = pwdata[7:0];
            IDX_PAT_SECOND: pat_d[1] = pwdata[7:0];
            IDX_PAT_THIRD: pat_d[2] = pwdata[7:0];
            IDX_PAT_LAST: pat_d[3] = pwdata[7:0];
            IDX_TX_CFG: tx_cfg_d = pwdata[7:0] & TX_CFG_MASK;
            IDX_SLICE_MODE: mode_d = pwdata[7:0] & MODE_MASK;
            default: mode_d = mode_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pat_ctrl_q <= RST_PAT_CTRL;
         thresh_q <= RST_THRESH;
         rssi_q <= RST_RSSI;
         peak_avg_q <= RST_PEAK_AVG;
         tx_cfg_q <= RST_TX_CFG;
         mode_q <= RST_SLICE_MODE;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            pat_q[i] <= RST_PAT;
         end
      end else begin
         pat_ctrl_q <= pat_ctrl_d;
         thresh_q <= thresh_d;
         rssi_q <= rssi_d;
         peak_avg_q <= peak_avg_d;
         tx_cfg_q <= tx_cfg_d;
         mode_q <= mode_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
         for (int i = 0; i < 4; i++) begin
            pat_q[i] <= pat_d[i];
         end
      end
   end

   // ----------------------------------------
   // field views
   // ----------------------------------------
   logic [2:0] peak_decay_step;
   logic [2:0] peak_update_rate;
   logic [1:0] average_filter_coeff;
   logic [1:0] pattern_byte_count;
   logic recog_en;
   logic [1:0] slice_mode;
   logic [31:0] pattern_word;

   assign peak_decay_step = peak_avg_q[STEP_LSB +: 3];
   assign peak_update_rate = peak_avg_q[RATE_LSB +: 3];
   assign average_filter_coeff = peak_avg_q[COEFF_LSB +: 2];
   assign pattern_byte_count = pat_ctrl_q[PAT_CNT_LSB +: 2];
   assign recog_en = pat_ctrl_q[PAT_RECOG_BIT];
   assign slice_mode = mode_q[MODE_LSB +: 2];
   assign pattern_word = {pat_q[0], pat_q[1], pat_q[2], pat_q[3]};
   assign transmit_smoothing_bw_o = tx_cfg_q[SMOOTH_LSB +: 4];
   assign tx_power_code_o = tx_cfg_q[POWER_LSB +: 3];

   // averaging shift 5,3,2,1 gives chip/32pi .. chip/2pi
   always_comb begin
      case (average_filter_coeff)
         2'b00: average_filter_coeff_o = 3'd5;
         2'b01: average_filter_coeff_o = 3'd3;
         2'b10: average_filter_coeff_o = 3'd2;
         default: average_filter_coeff_o = 3'd1;
      endcase
   end

   // ----------------------------------------
   // peak pacing
   // ----------------------------------------
   logic peak_update;

   ookt_update_pacer u_pacer (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .sub_tick_i(sub_tick_i),
      .rate_i(peak_update_rate),
      .update_o(peak_update)
   );

   // ----------------------------------------
   // peak tracker, averager and slicer
   // ----------------------------------------
   logic [7:0] peak_q, peak_d;
   logic [7:0] avg_q, avg_d;
   logic [7:0] thr_q, thr_d;
   logic slice_q, slice_d;
   logic [7:0] step;
   logic [8:0] diff;

   assign step = step_half_db(peak_decay_step);
   assign diff = {1'b0, rssi_i} - {1'b0, avg_q};

   always_comb begin
      peak_d = peak_q;
      avg_d = avg_q;
      if (peak_update) begin
         peak_d = (peak_q > step) ? peak_q - step : 8'h00;
      end
      if (rssi_valid_i && rssi_i > peak_d) begin
         peak_d = rssi_i;
      end
      if (chip_tick_i) begin
         avg_d = avg_q + 8'(signed'(diff) >>> average_filter_coeff_o);
      end
      case (slice_mode)
         MODE_PEAK: thr_d = (peak_q > thresh_q) ? peak_q : thresh_q;
         MODE_AVG: thr_d = avg_q;
         default: thr_d = thresh_q;
      endcase
      slice_d = slice_q;
      if (rssi_valid_i) begin
         slice_d = (rssi_i >= thr_q);
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         peak_q <= 8'h00;
         avg_q <= 8'h00;
         thr_q <= RST_THRESH;
         slice_q <= 1'b0;
      end else begin
         peak_q <= peak_d;
         avg_q <= avg_d;
         thr_q <= thr_d;
         slice_q <= slice_d;
      end
   end

   assign slicer_threshold_o = thr_q;
   assign slice_bit_o = slice_q;

   // ----------------------------------------
   // start pattern detector
   // ----------------------------------------
   logic [31:0] rx_sh_q, rx_sh_d;
   logic found_q, found_d;
   logic [31:0] want;

   assign want = pattern_word >> {3'b011 - {1'b0, pattern_byte_count}, 3'b000};

   always_comb begin
      rx_sh_d = rx_sh_q;
      found_d = 1'b0;
      if (rx_bit_tick_i) begin
         rx_sh_d = {rx_sh_q[30:0], rx_bit_i};
         found_d = recog_en &&
            ((rx_sh_d & byte_mask(pattern_byte_count)) == (want & byte_mask(pattern_byte_count)));
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_sh_q <= 32'h0000_0000;
         found_q <= 1'b0;
      end else begin
         rx_sh_q <= rx_sh_d;
         found_q <= found_d;
      end
   end

   assign pattern_found_o = found_q;

   // ----------------------------------------
   // start pattern transmitter
   // ----------------------------------------
   ookt_pattern_tx u_tx (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tx_start_i),
      .bit_tick_i(tx_bit_tick_i),
      .pattern_i(pattern_word),
      .count_i(pattern_byte_count),
      .busy_o(tx_busy_o),
      .bit_o(tx_bit_o)
   );
endmodule

// [ookt_host_model.sv]
`timescale 1ns/100ps
module ookt_host_model (
   // clock
   input wire logic clk_sys_i,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // one apb transfer, waits for pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      int n;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) tb_top.give_up();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// [ookt_pattern_tx.sv]
`timescale 1ns/100ps
module ookt_pattern_tx
   import ookt_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // control
   input wire logic start_i,
   input wire logic bit_tick_i,
   input wire logic [31:0] pattern_i,
   input wire logic [1:0] count_i,
   // serial out
   output logic busy_o,
   output logic bit_o
);
   ookt_tx_state_t state_q, state_d;
   logic [31:0] sh_q, sh_d;
   logic [5:0] left_q, left_d;

   // ----------------------------------------
   // msb-first serialiser
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      sh_d = sh_q;
      left_d = left_q;
      case (state_q)
         TX_IDLE: begin
            if (start_i) begin
               sh_d = pattern_i;
               left_d = {1'b0, count_i, 3'b111} + 6'h01;
               state_d = TX_SEND;
            end
         end
         TX_SEND: begin
            if (bit_tick_i) begin
               sh_d = {sh_q[30:0], 1'b0};
               left_d = left_q - 6'h01;
               if (left_q == 6'h01) begin
                  state_d = TX_IDLE;
               end
            end
         end
         default: begin
            state_d = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= TX_IDLE;
         sh_q <= 32'h0000_0000;
         left_q <= 6'h00;
      end else begin
         state_q <= state_d;
         sh_q <= sh_d;
         left_q <= left_d;
      end
   end

   assign busy_o = (state_q == TX_SEND);
   assign bit_o = sh_q[31];
endmodule

// [ookt_pkg.sv]
package ookt_pkg;
   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [5:0] IDX_PAT_CTRL = 6'h12;
   localparam logic [5:0] IDX_THRESH = 6'h13;
   localparam logic [5:0] IDX_RSSI = 6'h14;
   localparam logic [5:0] IDX_PEAK_AVG = 6'h15;
   localparam logic [5:0] IDX_PAT_FIRST = 6'h16;
   localparam logic [5:0] IDX_PAT_SECOND = 6'h17;
   localparam logic [5:0] IDX_PAT_THIRD = 6'h18;
   localparam logic [5:0] IDX_PAT_LAST = 6'h19;
   localparam logic [5:0] IDX_TX_CFG = 6'h1A;
   localparam logic [5:0] IDX_SLICE_MODE = 6'h20;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_PAT_CTRL = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'h0C;
   localparam logic [7:0] RST_RSSI = 8'h00;
   localparam logic [7:0] RST_PEAK_AVG = 8'h00;
   localparam logic [7:0] RST_PAT = 8'h00;
   localparam logic [7:0] RST_TX_CFG = 8'h70;
   localparam logic [7:0] RST_SLICE_MODE = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PAT_RECOG_BIT = 5;
   localparam int PAT_CNT_LSB = 3;
   localparam int STEP_LSB = 5;
   localparam int RATE_LSB = 2;
   localparam int COEFF_LSB = 0;
   localparam int SMOOTH_LSB = 4;
   localparam int POWER_LSB = 1;
   localparam int MODE_LSB = 0;
   localparam logic [7:0] TX_CFG_MASK = 8'hFE;
   localparam logic [7:0] PAT_CTRL_MASK = 8'h38;
   localparam logic [7:0] MODE_MASK = 8'h03;
   // ----------------------------------------
   // slicer modes and timing
   // ----------------------------------------
   localparam logic [1:0] MODE_FIXED = 2'h0;
   localparam logic [1:0] MODE_PEAK = 2'h1;
   localparam logic [1:0] MODE_AVG = 2'h2;
   localparam logic [7:0] SUB_TICKS_PER_CHIP = 8'h10;
   localparam int PAT_BITS = 32;
   // ----------------------------------------
   // state types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } ookt_tx_state_t;
endpackage

// [ookt_regs_asserts.sv]
`timescale 1ns/100ps
module ookt_regs_asserts
   import ookt_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // datapath
   input wire logic [7:0] rssi_i,
   input wire logic rssi_valid_i,
   input wire logic [7:0] slicer_threshold_o,
   input wire logic pattern_found_o,
   input wire logic tx_start_i,
   input wire logic tx_bit_tick_i,
   input wire logic tx_busy_o,
   input wire logic tx_bit_o,
   input wire logic [3:0] transmit_smoothing_bw_o,
   input wire logic [2:0] tx_power_code_o,
   input wire logic [2:0] average_filter_coeff_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------
   // shadow of written fields and of rssi, plus transmit bit tick count
   // ----------------------------------------
   logic wr;
   logic [7:0] thr_q;
   logic [7:0] rssi_q;
   logic [7:0] first_q;
   logic [1:0] mode_q;
   logic [1:0] cnt_q;
   logic recog_q;
   logic [5:0] ticks_q;
   assign wr = psel & penable & pwrite;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         thr_q <= 8'h0C;
         rssi_q <= 8'h00;
         first_q <= 8'h00;
         mode_q <= 2'h0;
         cnt_q <= 2'h0;
         recog_q <= 1'b0;
         ticks_q <= 6'h00;
      end else begin
         if (wr && paddr == 8'h4C) thr_q <= pwdata[7:0];
         if (wr && paddr == 8'h58) first_q <= pwdata[7:0];
         if (wr && paddr == 8'h80) mode_q <= pwdata[1:0];
         if (wr && paddr == 8'h48) cnt_q <= pwdata[4:3];
         if (wr && paddr == 8'h48) recog_q <= pwdata[5];
         if (rssi_valid_i) rssi_q <= rssi_i;
         ticks_q <= !tx_busy_o ? 6'h00 : ticks_q + {5'h00, tx_bit_tick_i};
      end
   end
   property p_thr_fixed;
      mode_q == MODE_FIXED && $past(mode_q) == MODE_FIXED |-> slicer_threshold_o == $past(thr_q);
   endproperty
   a_thr_fixed: assert property (p_thr_fixed) else $error("fixed threshold differs");
   property p_bw;
      wr && paddr == 8'h68 |=> transmit_smoothing_bw_o == $past(pwdata[7:4]);
   endproperty
   a_bw: assert property (p_bw) else $error("smoothing bandwidth not applied");
   property p_pow;
      wr && paddr == 8'h68 |=> tx_power_code_o == $past(pwdata[3:1]);
   endproperty
   a_pow: assert property (p_pow) else $error("power code not applied");
   property p_coeff;
      wr && paddr == 8'h54 |=> average_filter_coeff_o == ($past(pwdata[1:0]) == 2'h0 ? 3'h5 :
         $past(pwdata[1:0]) == 2'h1 ? 3'h3 : $past(pwdata[1:0]) == 2'h2 ? 3'h2 : 3'h1);
   endproperty
   a_coeff: assert property (p_coeff) else $error("filter coefficient wrong");
   property p_rssi;
      psel && penable && !pwrite && paddr == 8'h50 |-> prdata == {24'h000000, $past(rssi_q)};
   endproperty
   a_rssi: assert property (p_rssi) else $error("signal strength read wrong");
   property p_tx_first;
      tx_start_i && !tx_busy_o |=> tx_busy_o && tx_bit_o == first_q[7];
   endproperty
   a_tx_first: assert property (p_tx_first) else $error("first pattern bit wrong");
   property p_tx_len;
      $fell(tx_busy_o) |-> ticks_q == {3'(cnt_q) + 3'h1, 3'h0};
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("pattern length wrong");
   property p_recog;
      !recog_q && !$past(recog_q) |-> !pattern_found_o;
   endproperty
   a_recog: assert property (p_recog) else $error("match while detection off");
   c_tx: cover property ($fell(tx_busy_o));
   c_found: cover property (pattern_found_o);
   c_rssi: cover property (psel && penable && !pwrite && paddr == 8'h50);
endmodule
bind ookt_config_regs ookt_regs_asserts u_chk (.clk_sys_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .rssi_i, .rssi_valid_i, .slicer_threshold_o, .pattern_found_o, .tx_start_i, .tx_bit_tick_i,
   .tx_busy_o, .tx_bit_o, .transmit_smoothing_bw_o, .tx_power_code_o, .average_filter_coeff_o);

// [ookt_update_pacer.sv]
`timescale 1ns/100ps
module ookt_update_pacer
   import ookt_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // timing
   input wire logic sub_tick_i,
   input wire logic [2:0] rate_i,
   // strobe
   output logic update_o
);
   logic [7:0] cnt_q, cnt_d;
   logic upd_q, upd_d;
   logic [7:0] period;

   // ----------------------------------------
   // update period in sub-chip ticks
   // ----------------------------------------
   always_comb begin
      if (rate_i[2]) begin
         period = SUB_TICKS_PER_CHIP >> rate_i[1:0] >> 1;
      end else begin
         period = SUB_TICKS_PER_CHIP << rate_i[1:0];
      end
   end

   always_comb begin
      cnt_d = cnt_q;
      upd_d = 1'b0;
      if (sub_tick_i) begin
         if (cnt_q + 8'h01 >= period) begin
            cnt_d = 8'h00;
            upd_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= 8'h00;
         upd_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         upd_q <= upd_d;
      end
   end

   assign update_o = upd_q;
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import ookt_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] rssi_i = 8'h00;
   logic rssi_valid_i = 1'b0, sub_tick_i = 1'b0, rx_bit_i = 1'b0, rx_bit_tick_i = 1'b0;
   logic tx_start_i = 1'b0, tx_bit_tick_i = 1'b0, chip_tick_i = 1'b0;
   logic [7:0] slicer_threshold_o;
   logic slice_bit_o, pattern_found_o, tx_busy_o, tx_bit_o, seen;
   logic [3:0] transmit_smoothing_bw_o;
   logic [2:0] tx_power_code_o, average_filter_coeff_o;
   int errors = 0;
   int checks_done = 0;
   logic [7:0] adr [10] = '{8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68, 8'h80};
   logic [7:0] rstv [10] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00};
   logic [7:0] msk [10] = '{8'h38, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h03};
   int pn [8] = '{16, 32, 64, 128, 8, 4, 2, 1};
   int st [8] = '{1, 2, 3, 4, 6, 8, 10, 12};
   logic [2:0] cf [4] = '{3'h5, 3'h3, 3'h2, 3'h1};
   localparam logic [31:0] PAT = 32'hA53C960F;
   always #50 clk_sys_i = ~clk_sys_i;
   ookt_host_model u_host (.clk_sys_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ookt_config_regs u_dut (.clk_sys_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rssi_i, .rssi_valid_i, .chip_tick_i, .sub_tick_i, .rx_bit_i, .rx_bit_tick_i,
      .slicer_threshold_o, .slice_bit_o, .pattern_found_o, .tx_start_i, .tx_bit_tick_i, .tx_busy_o, .tx_bit_o,
      .transmit_smoothing_bw_o, .tx_power_code_o, .average_filter_coeff_o);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic give_up();
      errors++;
      results();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      u_host.xfer(1'b1, a, d, r, e);
      @(posedge clk_sys_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] r;
      logic e;
      u_host.xfer(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check(e, err);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_sys_i);
      case (k)
         0: rssi_valid_i <= 1'b1;
         1: sub_tick_i <= 1'b1;
         2: tx_start_i <= 1'b1;
         3: tx_bit_tick_i <= 1'b1;
         5: chip_tick_i <= 1'b1;
         default: rx_bit_tick_i <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      {rssi_valid_i, sub_tick_i, tx_start_i, tx_bit_tick_i, rx_bit_tick_i, chip_tick_i} <= 6'h00;
   endtask
   task automatic rx_byte(input logic [7:0] b, input logic exp);
      for (int i = 7; i >= 0; i--) begin
         rx_bit_i <= b[i];
         pulse(4);
      end
      seen = 1'b0;
      repeat (3) begin
         @(posedge clk_sys_i);
         seen = seen | pattern_found_o;
      end
      check(seen, exp);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) rd_chk(adr[i], rstv[i], 1'b0);
      check(transmit_smoothing_bw_o, 4'h7);
      for (int i = 0; i < 10; i++) begin
         wr(adr[i], 32'hFFFFFFFF);
         rd_chk(adr[i], msk[i], 1'b0);
      end
      rd_chk(8'h84, 32'h0, 1'b1);
      rd_chk(8'h49, 32'h0, 1'b1);
      $display("register test done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h54, c);
         check(average_filter_coeff_o, cf[c]);
      end
      for (int p = 0; p < 8; p++) begin
         wr(8'h68, {p[3:0], p[2:0], 1'b1});
         check({transmit_smoothing_bw_o, tx_power_code_o}, {p[3:0], p[2:0]});
      end
      $display("field test done");
      wr(8'h80, 32'h0);
      wr(8'h4C, 32'h20);
      rssi_i <= 8'h21;
      pulse(0);
      repeat (2) @(posedge clk_sys_i);
      check({slicer_threshold_o, slice_bit_o}, {8'h20, 1'b1});
      rssi_i <= 8'h1F;
      pulse(0);
      repeat (2) @(posedge clk_sys_i);
      check(slice_bit_o, 1'b0);
      wr(8'h50, 32'h55);
      rd_chk(8'h50, 32'h1F, 1'b0);
      $display("fixed slicer test done");
      wr(8'h80, 32'h1);
      wr(8'h4C, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(8'h54, {i[2:0], i[2:0], 2'b00});
         rssi_i <= 8'hF0;
         pulse(0);
         repeat (2) @(posedge clk_sys_i);
         for (int t = 0; t < 2 * pn[i]; t++) pulse(1);
         repeat (3) @(posedge clk_sys_i);
         check(slicer_threshold_o, 8'hF0 - 8'(2 * st[i]));
      end
      $display("peak test done");
      wr(8'h80, 32'h2);
      wr(8'h54, 32'h3);
      rssi_i <= 8'h40;
      for (int t = 0; t < 3; t++) pulse(5);
      repeat (2) @(posedge clk_sys_i);
      check(slicer_threshold_o, 8'h38);
      $display("average test done");
      for (int i = 0; i < 4; i++) wr(adr[4 + i], PAT[31 - 8 * i -: 8]);
      wr(8'h48, 32'h20);
      rx_byte(8'hA5, 1'b1);
      rx_byte(8'h5A, 1'b0);
      wr(8'h48, 32'h00);
      rx_byte(8'hA5, 1'b0);
      $display("detect test done");
      for (int c = 1; c < 4; c += 2) begin
         wr(8'h48, c << 3);
         pulse(2);
         for (int i = 0; i < 8 * (c + 1); i++) begin
            @(posedge clk_sys_i);
            check({tx_busy_o, tx_bit_o}, {1'b1, PAT[31 - i]});
            pulse(3);
         end
         @(posedge clk_sys_i);
         check(tx_busy_o, 1'b0);
      end
      $display("transmit test done");
      results();
   end
endmodule
